// ---- hw/rsu_top.sv ----
// Purpose: reset synchroniser, internal reset sequence, first strobe and usb clock control
// Assumes: reset pin is asynchronous
// Notes:   registers reached over a plain address, strobe and read data port
//
// Strobed register access and the register addresses were decided locally.
module rsu_top
	import rsu_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        reset_pin,
	input  wire logic        external_program_select,
	input  wire logic        pll_clk,
	input  wire logic [1:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	output logic             cpu_reset,
	output logic             addr_drive,
	output logic             addr_strobe,
	output logic             usb_if_reset,
	output logic             usb_core_reset,
	output logic             pll_run,
	output logic             usb_clk
);
	typedef struct packed {
		logic [1:0]  pin_sync;
		logic [3:0]  phase;
		rsu_state_e  st;
		logic [1:0]  mcnt;
		logic        drive;
		logic        strobe;
		rsu_clkctl_s ctl;
		logic        usb_soft_reset_bit;
		logic [3:0]  swr_cnt;
		logic        endpoint_init_request_flag;
		logic [7:0]  rdata;
	} rsu_reg_s;

	rsu_reg_s q_r;
	rsu_reg_s q_nxt;
	logic     sample;

	// pin capture lands at the start of s5p2, seen two flops later
	assign sample = (q_r.phase == RSU_S5P1 + 4'h2);

	always_comb begin
		q_nxt = q_r;
		q_nxt.pin_sync = {q_r.pin_sync[0], reset_pin};
		// twelve phases make one machine cycle
		q_nxt.phase = (q_r.phase == 4'(RSU_PHASES - 1)) ? 4'h0 : q_r.phase + 4'h1;
		case (q_r.st)
			RSU_RUN: begin
				if (sample && q_r.pin_sync[1]) begin
					q_nxt.st   = RSU_HOLD;
					q_nxt.mcnt = 2'h0;
					q_nxt.drive  = 1'b0;
					q_nxt.strobe = 1'b0;
				end else if (q_r.drive && q_r.phase == RSU_S5P1) begin
					q_nxt.strobe = 1'b0;
				end
			end
			RSU_HOLD: begin
				if (sample) begin
					if (q_r.mcnt != RSU_RST_CYCLES) q_nxt.mcnt = q_r.mcnt + 2'h1;
					// stay while pin high, leave once two cycles done
					if (!q_r.pin_sync[1] && q_r.mcnt >= RSU_RST_CYCLES - 2'h1) begin
						q_nxt.st = RSU_WAIT;
					end
				end
			end
			RSU_WAIT: begin
				if (q_r.phase == RSU_S5P1 - 4'h1) begin
					q_nxt.st    = RSU_RUN;
					q_nxt.drive = external_program_select;
					q_nxt.strobe = external_program_select;
				end
			end
			default: q_nxt.st = RSU_HOLD;
		endcase
		// control register write
		if (wr && addr == RSU_OFS_CTRL) begin
			q_nxt.ctl.pll_en = wdata[RSU_BIT_PLL];
			q_nxt.ctl.speed  = wdata[RSU_BIT_SPEED];
			q_nxt.ctl.gate   = wdata[RSU_BIT_GATE];
			if (wdata[RSU_BIT_SWR]) begin
				q_nxt.usb_soft_reset_bit     = 1'b1;
				q_nxt.swr_cnt = 4'h0;
			end
		end
		if (wr && addr == RSU_OFS_STAT && wdata[RSU_BIT_ENDPOINT_INIT_REQUEST_FLAG]) q_nxt.endpoint_init_request_flag = 1'b0;
		if (q_r.usb_soft_reset_bit) begin
			q_nxt.swr_cnt = q_r.swr_cnt + 4'h1;
			if (q_r.swr_cnt == RSU_SWR_TICKS - 4'h1) begin
				q_nxt.usb_soft_reset_bit   = 1'b0;
				q_nxt.endpoint_init_request_flag = 1'b1; // set wins over clear
			end
		end
		// internal reset hold state clears control bits
		if (q_r.st == RSU_HOLD) begin
			q_nxt.ctl  = '0;
			q_nxt.usb_soft_reset_bit  = 1'b0;
		end
		q_nxt.rdata = 8'h00;
		if (rd) begin
			case (addr)
				RSU_OFS_CTRL: q_nxt.rdata = {3'h0, 1'b0, q_r.usb_soft_reset_bit, q_r.ctl.gate,
								q_r.ctl.speed, q_r.ctl.pll_en};
				RSU_OFS_STAT: q_nxt.rdata = {3'h0, q_r.endpoint_init_request_flag, q_r.usb_soft_reset_bit, 1'b0,
								q_r.st != RSU_RUN, q_r.drive};
				default:      q_nxt.rdata = 8'h00;
			endcase
		end
	end

	// internal reset runs on mclk, which the aux clock replaces off-chip
	always_ff @(posedge mclk) begin
		if (rst) begin
			q_r          <= '0;
			q_r.st       <= RSU_HOLD;
			q_r.ctl      <= rsu_clkctl_s'(RSU_CTRL_RST[2:0]);
		end else begin
			q_r <= q_nxt;
		end
	end

	rsu_usb_clk u_clk (
		.mclk    (mclk),
		.rst     (rst),
		.pll_clk (pll_clk),
		.ctl     (q_r.ctl),
		.pll_run (pll_run),
		.usb_clk (usb_clk)
	);

	assign rdata          = q_r.rdata;
	assign cpu_reset      = (q_r.st != RSU_RUN);
	assign addr_drive     = q_r.drive;
	assign addr_strobe    = q_r.strobe;
	assign usb_if_reset   = (q_r.st == RSU_HOLD);
	assign usb_core_reset = q_r.usb_soft_reset_bit;
endmodule : rsu_top

// ---- hw/rsu_pkg.sv ----
// Purpose: constants and carriers for the reset sequencer and usb clock control
// Assumes: mclk is the oscillator clock, one phase per mclk period
// Notes:   a machine cycle is six states of two phases, modelled as twelve mclk ticks
//
// Overview of operation
// - reset pin sampled once per machine cycle at state 5 phase 2
// - reset seen high starts two machine cycles of internal reset
// - internal reset completes even without oscillator, using auxiliary clock
// - source holds reset two machine cycles; device stays reset while high
// - release is detected at the next state 5 phase 2 sample
// - external fetch drives address at next s5p1, strobe falls one phase later
// - release to first strobe fall is one to under two machine cycles
// - usb clock is 48 MHz full speed or 6 MHz low speed
// - low speed usb clock is system clock divided by two
// - full speed clock comes from times four pll, running only when enabled
// - rate select picks pll output when set, divided clock when clear
// - usb clock enable gates the selected clock; clear means no clock
// - hardware reset clears pll enable, rate select and clock enable
// - machine cycle is six oscillator periods, twelve for minimum reset; the code uses twelve mclk periods, and 24 for reset
// - soft reset bit starts usb reset; hardware clears it, sets init flag
// - hardware reset resets only usb cpu interface and memory unit
package rsu_pkg;
	localparam int          RSU_PHASES     = 12;
	localparam logic [3:0]  RSU_S5P1       = 4'h8;
	localparam logic [3:0]  RSU_S5P2       = 4'h9;
	localparam logic [1:0]  RSU_RST_CYCLES = 2'h2;
	localparam logic [3:0]  RSU_SWR_TICKS  = 4'h8;
	localparam logic [1:0]  RSU_OFS_CTRL   = 2'h0;
	localparam logic [1:0]  RSU_OFS_STAT   = 2'h1;
	localparam int          RSU_BIT_PLL    = 0;
	localparam int          RSU_BIT_SPEED  = 1;
	localparam int          RSU_BIT_GATE   = 2;
	localparam int          RSU_BIT_SWR    = 3;
	localparam int          RSU_BIT_ENDPOINT_INIT_REQUEST_FLAG  = 4;
	localparam logic [7:0]  RSU_CTRL_RST   = 8'h00;

	typedef enum logic [1:0] {
		RSU_RUN   = 2'b00,
		RSU_HOLD  = 2'b01,
		RSU_WAIT  = 2'b10
	} rsu_state_e;

	typedef struct packed {
		logic       s_pll;
		logic       s_spd;
		logic       s_gate;
	} rsu_gsync_s;

	typedef struct packed {
		logic       pll_en;
		logic       speed;
		logic       gate;
	} rsu_clkctl_s;
endpackage : rsu_pkg

// ---- hw/rsu_usb_clk.sv ----
// Purpose: usb clock source select and glitch free gate
// Assumes: pll_clk is the times four pll output, supplied outside
// Notes:   controls are resynchronised to each source clock before gating
module rsu_usb_clk
	import rsu_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        pll_clk,
	input  wire rsu_clkctl_s ctl,
	output logic             pll_run,
	output logic             usb_clk
);
	logic       div_r;
	logic [1:0] ls_sync_r;
	logic [1:0] fs_sync_r;
	logic       ls_gate;
	logic       fs_gate;
	logic       fs_clr;
	logic       fs_busy;

	assign pll_run = ctl.pll_en;
	// pll side held clear while the pll is off, its clock then stands still
	assign fs_clr  = rst | ~ctl.pll_en;
	assign fs_busy = fs_sync_r[1] & ctl.pll_en;

	always_ff @(posedge mclk) begin
		if (rst) div_r <= 1'b0;
		else     div_r <= ~div_r;
	end

	// enable of each source waits until the other is off
	always_ff @(posedge mclk) begin
		if (rst) ls_sync_r <= 2'b00;
		else     ls_sync_r <= {ls_sync_r[0], ctl.gate & ~ctl.speed & ~fs_busy};
	end

	always_ff @(posedge pll_clk or posedge fs_clr) begin
		if (fs_clr) fs_sync_r <= 2'b00;
		else     fs_sync_r <= {fs_sync_r[0], ctl.gate & ctl.speed & ctl.pll_en & ~ls_sync_r[1]};
	end

	// latch the enable while the source clock is low
	always_latch begin
		if (!div_r) ls_gate = ls_sync_r[1];
	end

	always_latch begin
		if (!pll_clk) fs_gate = fs_sync_r[1];
	end

	assign usb_clk = (div_r & ls_gate) | (pll_clk & fs_gate);
endmodule : rsu_usb_clk

// ---- verif/rsu_chk.sv ----
// Purpose: port checks of rsu_top
// Assumes: one clock domain
// Notes:   bound to every rsu_top
module rsu_chk (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       rd,
	input wire logic       reset_pin,
	input wire logic       external_program_select,
	input wire logic [7:0] rdata,
	input wire logic       cpu_reset,
	input wire logic       addr_drive,
	input wire logic       addr_strobe,
	input wire logic       usb_if_reset,
	input wire logic       usb_core_reset,
	input wire logic       pll_run
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] pin_cnt_r;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// consecutive cycles of pin high
	always_ff @(posedge mclk) begin
		pin_cnt_r <= !reset_pin ? 5'h00 : pin_cnt_r + {4'h0, pin_cnt_r != 5'h1f};
	end
	AST_RST: assert property (disable iff (1'b0) rst |=> cpu_reset && usb_if_reset && !pll_run)
		else $error("reset state wrong");
	AST_PIN: assert property (pin_cnt_r >= 5'h10 |-> cpu_reset)
		else $error("pin reset not taken");
	AST_REL: assert property ($fell(cpu_reset) |-> !$past(reset_pin, 2))
		else $error("release with pin high");
	AST_STB: assert property ($rose(addr_drive) |-> addr_strobe ##1 !addr_strobe)
		else $error("strobe edge wrong");
	AST_EXT: assert property ($rose(addr_drive) |-> external_program_select)
		else $error("address drive without external fetch");
	AST_HOLD: assert property (addr_drive |-> !cpu_reset)
		else $error("address driven in reset");
	AST_SWR: assert property ($rose(usb_core_reset) |-> usb_core_reset[*8] ##1 !usb_core_reset)
		else $error("soft reset length wrong");
	AST_RDQ: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule : rsu_chk

bind rsu_top rsu_chk u_chk (.mclk(mclk), .rst(rst), .rd(rd), .reset_pin(reset_pin),
	.external_program_select(external_program_select), .rdata(rdata), .cpu_reset(cpu_reset),
	.addr_drive(addr_drive), .addr_strobe(addr_strobe), .usb_if_reset(usb_if_reset),
	.usb_core_reset(usb_core_reset), .pll_run(pll_run));

// ---- verif/rsu_src_mdl.sv ----
// Purpose: reset source and pll model
// Assumes: pll output stands low while disabled
// Notes:   a reset request is stretched to two machine cycles
module rsu_src_mdl (
	input  wire logic mclk,
	input  wire logic req,
	input  wire logic pll_on,
	output logic      reset_pin,
	output logic      pll_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	int hold_cnt = 0;
	always @(posedge mclk) hold_cnt <= req ? 24 : (hold_cnt > 0 ? hold_cnt - 1 : 0);
	assign reset_pin = req || hold_cnt > 0;
	initial pll_clk = 1'b0;
	always #12.5 pll_clk = pll_on ? ~pll_clk : 1'b0;
endmodule : rsu_src_mdl

// ---- verif/tb_reset_sync_and_usb_clock_control.sv ----
// Purpose: register and reset sequence test of rsu_top
// Assumes: external fetch selected except in the last reset
// Notes:   pll lock wait shortened
module tb_reset_sync_and_usb_clock_control import rsu_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic       mclk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, rd = 1'b0, b, ext = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic       reset_pin, pll_clk, cpu_reset, addr_drive, addr_strobe, usb_if_reset;
	logic       usb_core_reset, pll_run, usb_clk;
	int         error_cnt = 0, n_compared = 0, cyc = 0, n;
	realtime    t0;
	rsu_src_mdl mdl (.mclk(mclk), .req(req), .pll_on(pll_run), .reset_pin(reset_pin),
		.pll_clk(pll_clk));
	rsu_top dut (.mclk(mclk), .rst(rst), .reset_pin(reset_pin), .external_program_select(ext),
		.pll_clk(pll_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.cpu_reset(cpu_reset), .addr_drive(addr_drive), .addr_strobe(addr_strobe),
		.usb_if_reset(usb_if_reset), .usb_core_reset(usb_core_reset), .pll_run(pll_run),
		.usb_clk(usb_clk));
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wr_reg(logic [1:0] a, logic [7:0] d);
		@(posedge mclk) {addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge mclk) wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(logic [1:0] a, logic [7:0] exp);
		@(posedge mclk) {addr, rd} <= {a, 1'b1};
		@(posedge mclk) rd <= 1'b0;
		#1 check("rdata", rdata, exp);
	endtask : rd_reg
	task automatic period(logic [7:0] exp);
		@(posedge usb_clk) t0 = $realtime;
		@(posedge usb_clk) check("usb period", 8'(int'($realtime - t0)), exp);
	endtask : period
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		rd_reg(RSU_OFS_CTRL, 8'h00);
		for (n = 0; cpu_reset !== 1'b0 && n < 100; n++) @(posedge mclk);
		rd_reg(RSU_OFS_STAT, 8'h01);
		wr_reg(RSU_OFS_CTRL, 8'h04);
		period(8'd200);
		check("pll off", {7'h0, pll_run}, 8'h00);
		wr_reg(RSU_OFS_CTRL, 8'h01);
		repeat (30) @(posedge mclk);
		wr_reg(RSU_OFS_CTRL, 8'h07);
		period(8'd25);
		wr_reg(RSU_OFS_CTRL, 8'h03);
		repeat (10) @(posedge mclk);
		b = usb_clk;
		n = 0;
		repeat (40) #7 n += int'(usb_clk !== b);
		check("gated", 8'(n), 8'h00);
		wr_reg(RSU_OFS_CTRL, 8'h0b);
		rd_reg(RSU_OFS_STAT, 8'h09);
		repeat (12) @(posedge mclk);
		rd_reg(RSU_OFS_STAT, 8'h11);
		wr_reg(RSU_OFS_STAT, 8'h10);
		rd_reg(RSU_OFS_STAT, 8'h01);
		rd_reg(2'h2, 8'h00);
		@(posedge mclk) req <= 1'b1;
		@(posedge mclk) req <= 1'b0;
		for (n = 0; cpu_reset !== 1'b1 && n < 40; n++) @(posedge mclk);
		check("pin taken", 8'(n >= 3 && n < 15), 8'h01);
		check("if reset", {7'h0, usb_if_reset}, 8'h01);
		while (reset_pin !== 1'b0) @(posedge mclk);
		for (n = 0; addr_drive !== 1'b1 && n < 60; n++) @(posedge mclk);
		check("release", 8'(n >= 12 && n < 24), 8'h01);
		check("strobe", {6'h0, addr_drive, addr_strobe}, 8'h03);
		#1 check("strobe fall", {6'h0, addr_drive, addr_strobe}, 8'h02);
		rd_reg(RSU_OFS_CTRL, 8'h00);
		ext <= 1'b0;
		@(posedge mclk) req <= 1'b1;
		@(posedge mclk) req <= 1'b0;
		for (n = 0; cpu_reset !== 1'b1 && n < 40; n++) @(posedge mclk);
		while (reset_pin !== 1'b0) @(posedge mclk);
		for (n = 0; cpu_reset !== 1'b0 && n < 60; n++) @(posedge mclk);
		check("internal fetch", {6'h0, cpu_reset, addr_drive}, 8'h00);
		finish_test();
	end
endmodule : tb_reset_sync_and_usb_clock_control
